// ### src/fmcu_pkg.sv
package fmcu_pkg;
	// register offsets (byte addresses, one aligned word each)
	localparam logic [7:0] FMCU_OFS_ACR = 8'h00; // wait states, prefetch, half-cycle
	localparam logic [7:0] FMCU_OFS_KEY = 8'h04; // unlock_key_reg
	localparam logic [7:0] FMCU_OFS_STS = 8'h0C; // flash_status_reg
	localparam logic [7:0] FMCU_OFS_CTRL_A = 8'h10; // flash_control_reg_a
	localparam logic [7:0] FMCU_OFS_ADDR = 8'h14; // target address
	localparam logic [7:0] FMCU_OFS_CTRL_B = 8'h18; // flash_control_reg_b
	localparam logic [7:0] FMCU_OFS_PROT = 8'h1C; // protection byte and write-protect mask
	// access control field positions
	localparam int FMCU_ACR_WAIT_BIT = 0;
	localparam int FMCU_ACR_HALF_BIT = 3;
	localparam int FMCU_ACR_PREF_BIT = 4;
	localparam int FMCU_ACR_PREF_STS_BIT = 5;
	// control register a field positions
	localparam int FMCU_CA_PROG_BIT = 0;
	localparam int FMCU_CA_PAGE_BIT = 1;
	localparam int FMCU_CA_MASS_BIT = 2;
	localparam int FMCU_CA_START_BIT = 6;
	localparam int FMCU_CA_LOCK_BIT = 7;
	localparam int FMCU_CA_IRQ_EN_BIT = 12;
	// control register b field positions
	localparam int FMCU_CB_LOCK_BIT = 0;
	// status field positions (done and error flags write one to clear, busy is read-only)
	localparam int FMCU_ST_BUSY_BIT = 0;
	localparam int FMCU_ST_PERR_BIT = 2;
	localparam int FMCU_ST_WPERR_BIT = 4;
	localparam int FMCU_ST_DONE_BIT = 5;
	// unlock keys
	localparam logic [31:0] FMCU_KEY_FIRST = 32'h4567_0123;
	localparam logic [31:0] FMCU_KEY_SECOND = 32'hCDEF_89AB;
	// protection byte codes
	localparam logic [7:0] FMCU_RDP_L0 = 8'hAA;
	localparam logic [7:0] FMCU_RDP_L2 = 8'hCC;
	// clock limits in MHz
	localparam int FMCU_F_WAIT0_MAX = 24;
	localparam int FMCU_F_WAIT1_MAX = 48;
	localparam int FMCU_F_HALF_MAX = 8;
	localparam int FMCU_F_PREF_MAX = 24;
	// array geometry and values
	localparam logic [15:0] FMCU_ERASED = 16'hFFFF;
	localparam int FMCU_PAGE_BYTES = 1024;
	localparam int FMCU_WP_GROUP_PAGES = 4;
	// reset values
	localparam logic FMCU_PREF_RST = 1'b1;
	// unlock sequencer states
	typedef enum logic [1:0] {FMCU_LK_LOCKED, FMCU_LK_GOT1, FMCU_LK_OPEN, FMCU_LK_DEAD} fmcu_lock_t;
	// operation sequencer states
	typedef enum logic [1:0] {FMCU_OP_IDLE, FMCU_OP_PROG, FMCU_OP_ERASE} fmcu_op_t;
endpackage

// ### src/fmcu_flash_ctrl_unit.sv
`timescale 1ns/1ps
// Functional notes
// - zero wait to 24MHz, one to 48MHz
// - prefetch on after every reset
// - prefetch change only equal clocks below 24MHz
// - half-cycle only equal clocks, at most 8MHz
// - erase leaves halfwords at 0xFFFF
// - page erase touches only selected page
// - erase, or program to an unprotected target with program error flag clear, sets operation-done flag
// - done flag with enable raises interrupt
// - mass erase clears whole array
// - programming one halfword per operation
// - unerased target discards write, sets error
// - protected target discards write, sets error
// - write protection per four-page group
// - protection byte decodes to three levels
// - level 0 allows everything
// - level 1 user code allows everything
// - level 2 blocks debug, array, options; frozen
// - system memory rejects program and erase
// - up to 64KB, 1KB pages
// - locked after reset, two-key unlock
// - wrong key locks until reset
// - writing lock bit relocks at once
module fmcu_flash_ctrl_unit
	import fmcu_pkg::*;
#(
	parameter int SYS_MHZ = 125, // system clock rate in MHz
	parameter int PAGES = 64, // main-array pages
	parameter int ERASE_CYCLES = 64 // cycles an erase step takes
) (
	input wire logic clk, // system clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic bus_clk_equal, // bus clock equals system clock
	input wire logic dbg_or_ram_boot, // debug or running from sram/sysmem
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [31:0] reg_rdata, // register read data
	input wire logic arr_rd, // array read request
	input wire logic [15:0] arr_addr, // array byte address
	output logic arr_ready, // array read taken
	output logic [15:0] arr_rdata, // array read data
	output logic arr_rvalid, // array read data valid
	output logic arr_denied, // array read refused by protection
	input wire logic sysmem_wr, // attempt to modify system memory
	output logic op_done_irq, // operation-complete interrupt
	output logic debug_enable // debug access allowed
);
	// derived geometry
	// 1KB pages at consecutive addresses
	localparam int WORDS = PAGES * FMCU_PAGE_BYTES / 2; // halfwords in array
	localparam int AW = $clog2(WORDS); // halfword address width
	localparam int PW = $clog2(PAGES); // page index width
	localparam int GROUPS = PAGES / FMCU_WP_GROUP_PAGES; // protection groups
	localparam int HPW = $clog2(FMCU_PAGE_BYTES / 2); // halfword-in-page bits
	localparam int EW = $clog2(ERASE_CYCLES + 1); // erase counter width
	// wait states and options permitted by clock rate
	localparam logic NEED_WAIT = (SYS_MHZ > FMCU_F_WAIT0_MAX); // rate split
	localparam logic PREF_CFG_OK = (SYS_MHZ < FMCU_F_PREF_MAX);
	localparam logic HALF_OK = (SYS_MHZ <= FMCU_F_HALF_MAX);

	// registers and helpers
	logic [15:0] mem_r [WORDS]; // main array
	fmcu_lock_t lock_r; // unlock sequencer
	fmcu_op_t op_r; // operation sequencer
	logic pref_r; // prefetch enable
	logic half_r; // half-cycle enable
	logic wait_r; // programmed wait states
	logic prog_r; // program mode
	logic page_r; // page erase mode
	logic mass_r; // mass erase mode
	logic irq_en_r; // op_done_irq_en
	logic op_done_flag_r; // op_done_flag
	logic prog_error_flag_r; // prog_error_flag
	logic wprot_error_flag_r; // wprot_error_flag
	logic [15:0] tgt_r; // target address
	logic [7:0] prot_byte_r; // protection byte
	logic [GROUPS-1:0] wp_mask_r; // one bit per protected group
	logic [EW-1:0] ecnt_r; // erase timer
	logic [AW-1:0] eidx_r; // erase halfword index
	logic [1:0] read_prot_level; // decoded level
	logic main_blocked; // array access blocked
	logic tgt_prot; // target in protected group
	logic rd_busy_r; // a read waits for its data
	logic [AW-1:0] rd_idx_r; // latched read index
	logic rd_wait_r; // wait state pending
	logic done_set; // completion event
	logic start_wr; // software start write
	logic [AW-1:0] tgt_idx; // target halfword index
	logic [PW-1:0] tgt_page; // target page
	logic [15:0] wr_data; // halfword to program

	// target address split into halfword and page
	assign tgt_idx = tgt_r[AW:1];
	assign tgt_page = tgt_r[AW:HPW+1];
	assign wr_data = reg_wdata[15:0];

	// protection level decode
	always_comb begin
		if (prot_byte_r == FMCU_RDP_L0) begin
			read_prot_level = 2'd0;
		end else if (prot_byte_r == FMCU_RDP_L2) begin
			read_prot_level = 2'd2;
		end else begin
			read_prot_level = 2'd1;
		end
	end

	// access gate per level and source
	assign main_blocked = (read_prot_level == 2'd2) || ((read_prot_level == 2'd1) && dbg_or_ram_boot);
	assign debug_enable = (read_prot_level != 2'd2);
	assign tgt_prot = wp_mask_r[tgt_page / FMCU_WP_GROUP_PAGES];
	assign start_wr = reg_wr && (reg_addr == FMCU_OFS_CTRL_A) && (lock_r == FMCU_LK_OPEN);

	// unlock sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lock_r <= FMCU_LK_LOCKED;
		end else if (reg_wr && reg_addr == FMCU_OFS_KEY) begin
			case (lock_r)
				// a dead sequencer leaves only through reset
				FMCU_LK_LOCKED: lock_r <= (reg_wdata == FMCU_KEY_FIRST) ? FMCU_LK_GOT1 : FMCU_LK_DEAD;
				FMCU_LK_GOT1: lock_r <= (reg_wdata == FMCU_KEY_SECOND) ? FMCU_LK_OPEN : FMCU_LK_DEAD;
				FMCU_LK_OPEN: lock_r <= FMCU_LK_DEAD;
				default: lock_r <= FMCU_LK_DEAD;
			endcase
		end else if (lock_r == FMCU_LK_GOT1 && reg_wr) begin
			// other write between keys breaks the sequence
			lock_r <= FMCU_LK_DEAD;
		end else if (reg_wr && reg_addr == FMCU_OFS_CTRL_B && reg_wdata[FMCU_CB_LOCK_BIT] && lock_r == FMCU_LK_OPEN) begin
			lock_r <= FMCU_LK_LOCKED;
		end else if (start_wr && reg_wdata[FMCU_CA_LOCK_BIT]) begin
			// lock bit in control a relocks too
			lock_r <= FMCU_LK_LOCKED;
		end
	end

	// access control register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pref_r <= FMCU_PREF_RST;
			// half-cycle off, no extra wait
			half_r <= 1'b0;
			wait_r <= 1'b0;
		end else begin
			// software write to access control
			if (reg_wr && reg_addr == FMCU_OFS_ACR) begin
				wait_r <= reg_wdata[FMCU_ACR_WAIT_BIT];
				if (bus_clk_equal && PREF_CFG_OK) begin
					pref_r <= reg_wdata[FMCU_ACR_PREF_BIT];
				end
				half_r <= reg_wdata[FMCU_ACR_HALF_BIT] && bus_clk_equal && HALF_OK;
			end else if (!(bus_clk_equal && HALF_OK)) begin
				half_r <= 1'b0;
			end
		end
	end

	// control register a, target and protection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// modes cleared, level 0, nothing protected
			prog_r <= 1'b0;
			page_r <= 1'b0;
			mass_r <= 1'b0;
			irq_en_r <= 1'b0;
			tgt_r <= 16'h0000;
			prot_byte_r <= FMCU_RDP_L0;
			wp_mask_r <= '0;
		end else begin
			// modes load only while idle
			if (start_wr && op_r == FMCU_OP_IDLE) begin
				prog_r <= reg_wdata[FMCU_CA_PROG_BIT];
				page_r <= reg_wdata[FMCU_CA_PAGE_BIT];
				mass_r <= reg_wdata[FMCU_CA_MASS_BIT];
				irq_en_r <= reg_wdata[FMCU_CA_IRQ_EN_BIT];
			end
			// level 1 to 0 erase spans the whole array
			if (reg_wr && reg_addr == FMCU_OFS_PROT && lock_r == FMCU_LK_OPEN && read_prot_level == 2'd1
				&& reg_wdata[7:0] == FMCU_RDP_L0 && op_r == FMCU_OP_IDLE) begin
				mass_r <= 1'b1;
			end
			// target address while idle
			if (reg_wr && reg_addr == FMCU_OFS_ADDR && lock_r == FMCU_LK_OPEN && op_r == FMCU_OP_IDLE) begin
				tgt_r <= reg_wdata[15:0];
			end
			// level 2 frozen; options still writable at level 1
			if (reg_wr && reg_addr == FMCU_OFS_PROT && lock_r == FMCU_LK_OPEN && read_prot_level != 2'd2
				&& op_r == FMCU_OP_IDLE) begin
				prot_byte_r <= reg_wdata[7:0];
				wp_mask_r <= reg_wdata[8 +: GROUPS];
			end
		end
	end

	// operation sequencer, array and flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// sequencer idle, nothing pending
			op_r <= FMCU_OP_IDLE;
			ecnt_r <= '0;
			eidx_r <= '0;
			done_set <= 1'b0;
		end else begin
			done_set <= 1'b0;
			case (op_r)
				FMCU_OP_IDLE: begin
					// wait for a level 1 to 0 write, start or data write
					if (reg_wr && reg_addr == FMCU_OFS_PROT && lock_r == FMCU_LK_OPEN
						&& read_prot_level == 2'd1 && reg_wdata[7:0] == FMCU_RDP_L0) begin
						op_r <= FMCU_OP_ERASE;
						eidx_r <= '0;
						ecnt_r <= EW'(ERASE_CYCLES);
					end else if (start_wr && reg_wdata[FMCU_CA_START_BIT] && !main_blocked
						&& (reg_wdata[FMCU_CA_MASS_BIT] || (reg_wdata[FMCU_CA_PAGE_BIT] && !tgt_prot))) begin
						op_r <= FMCU_OP_ERASE;
						eidx_r <= reg_wdata[FMCU_CA_MASS_BIT] ? '0 : {tgt_page, {HPW{1'b0}}};
						ecnt_r <= EW'(ERASE_CYCLES);
					end else if (reg_wr && reg_addr == FMCU_OFS_ADDR + 8'h04 && lock_r == FMCU_LK_OPEN
						&& prog_r && !main_blocked) begin
						op_r <= FMCU_OP_PROG;
						if (!tgt_prot && mem_r[tgt_idx] == FMCU_ERASED) begin
							mem_r[tgt_idx] <= wr_data;
						end
					end
				end
				FMCU_OP_PROG: begin
					// one busy cycle, then report
					op_r <= FMCU_OP_IDLE;
					done_set <= !tgt_prot && !prog_error_flag_r;
				end
				FMCU_OP_ERASE: begin
					if (ecnt_r != '0) begin
						// settle time before the first halfword
						ecnt_r <= ecnt_r - EW'(1);
					end else begin
						mem_r[eidx_r] <= FMCU_ERASED;
						eidx_r <= eidx_r + AW'(1);
						// stop at page end unless mass
						if ((!mass_r && eidx_r[HPW-1:0] == {HPW{1'b1}}) || eidx_r == AW'(WORDS - 1)) begin
							op_r <= FMCU_OP_IDLE;
							done_set <= 1'b1;
						end
					end
				end
				default: op_r <= FMCU_OP_IDLE;
			endcase
		end
	end

	// sticky status flags, set wins over clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// all flags clear at reset
			op_done_flag_r <= 1'b0;
			prog_error_flag_r <= 1'b0;
			wprot_error_flag_r <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == FMCU_OFS_STS) begin
				if (reg_wdata[FMCU_ST_DONE_BIT]) op_done_flag_r <= 1'b0;
				if (reg_wdata[FMCU_ST_PERR_BIT]) prog_error_flag_r <= 1'b0;
				if (reg_wdata[FMCU_ST_WPERR_BIT]) wprot_error_flag_r <= 1'b0;
			end
			if (done_set) op_done_flag_r <= 1'b1;
			if (op_r == FMCU_OP_IDLE && reg_wr && reg_addr == FMCU_OFS_ADDR + 8'h04 && lock_r == FMCU_LK_OPEN
				&& prog_r && !main_blocked) begin
				if (!tgt_prot && mem_r[tgt_idx] != FMCU_ERASED) prog_error_flag_r <= 1'b1;
				if (tgt_prot) wprot_error_flag_r <= 1'b1;
			end
			if (op_r == FMCU_OP_IDLE && start_wr && reg_wdata[FMCU_CA_START_BIT] && reg_wdata[FMCU_CA_PAGE_BIT]
				&& !reg_wdata[FMCU_CA_MASS_BIT] && tgt_prot) wprot_error_flag_r <= 1'b1;
			if (sysmem_wr) wprot_error_flag_r <= 1'b1;
		end
	end

	assign op_done_irq = op_done_flag_r && irq_en_r;

	// combinational take, one read in flight at a time
	// stall reads while busy; wait state
	assign arr_ready = arr_rd && op_r == FMCU_OP_IDLE && !rd_busy_r;

	// array read path
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// read path idle after reset
			rd_busy_r <= 1'b0;
			rd_wait_r <= 1'b0;
			rd_idx_r <= '0;
			arr_rvalid <= 1'b0;
			arr_rdata <= 16'h0000;
			arr_denied <= 1'b0;
		end else begin
			arr_rvalid <= 1'b0;
			arr_denied <= 1'b0;
			if (arr_ready) begin
				// latch the halfword index
				rd_idx_r <= arr_addr[AW:1];
				rd_wait_r <= NEED_WAIT || wait_r;
				rd_busy_r <= 1'b1;
			end else if (rd_busy_r && rd_wait_r) begin
				// wait state spent
				rd_wait_r <= 1'b0;
			end else if (rd_busy_r) begin
				// data cycle, refused if protected
				rd_busy_r <= 1'b0;
				arr_rvalid <= 1'b1;
				arr_denied <= main_blocked;
				arr_rdata <= main_blocked ? 16'h0000 : mem_r[rd_idx_r];
			end
		end
	end

	// register read mux
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			if (reg_addr == FMCU_OFS_ACR) begin
				// wait, half-cycle, prefetch and prefetch active
				reg_rdata <= 32'({pref_r && bus_clk_equal, pref_r, half_r, 2'b00, wait_r || NEED_WAIT});
			end else if (reg_addr == FMCU_OFS_STS) begin
				// sticky flags and busy
				reg_rdata <= 32'({op_done_flag_r, wprot_error_flag_r, 1'b0, prog_error_flag_r, 1'b0, op_r != FMCU_OP_IDLE});
			end else if (reg_addr == FMCU_OFS_CTRL_A) begin
				// modes, lock state at bit 7, enable at bit 12
				reg_rdata <= 32'({irq_en_r, 4'h0, lock_r != FMCU_LK_OPEN, 4'h0, mass_r, page_r, prog_r});
			end else if (reg_addr == FMCU_OFS_ADDR) begin
				// target address
				reg_rdata <= 32'(tgt_r);
			end else if (reg_addr == FMCU_OFS_PROT) begin
				// protection byte and group mask
				reg_rdata <= 32'({wp_mask_r, prot_byte_r});
			end else begin
				// unmapped offsets read zero
				reg_rdata <= 32'h0000_0000;
			end
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule // fmcu_flash_ctrl_unit

// ### verif/fmcu_flash_ctrl_unit_chk.sv
`timescale 1ns/1ps
// port-level checks on the flash controller
module fmcu_flash_ctrl_unit_chk
	import fmcu_pkg::*;
(
	input wire logic clk, // clock
	input wire logic sys_rst, // reset
	input wire logic bus_clk_equal, // clocks equal
	input wire logic dbg_or_ram_boot, // debug boot
	input wire logic [7:0] reg_addr, // address
	input wire logic [31:0] reg_wdata, // wdata
	input wire logic reg_wr, // write
	input wire logic reg_rd, // read
	input wire logic [31:0] reg_rdata, // rdata
	input wire logic arr_rd, // array req
	input wire logic [15:0] arr_addr, // array addr
	input wire logic arr_ready, // taken
	input wire logic [15:0] arr_rdata, // array data
	input wire logic arr_rvalid, // data valid
	input wire logic arr_denied, // refused
	input wire logic sysmem_wr, // sysmem attempt
	input wire logic op_done_irq, // irq
	input wire logic debug_enable // debug on
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_reset_quiet: assert property ($fell(sys_rst) |-> !op_done_irq && !arr_rvalid && debug_enable)
		else $error("outputs not idle after reset");
	a_read_wait: assert property (arr_rd && arr_ready |-> ##3 arr_rvalid)
		else $error("array data not three cycles after take");
	a_valid_cause: assert property (arr_rvalid |-> $past(arr_rd, 3) && $past(arr_ready, 3))
		else $error("array data without request");
	a_ready_req: assert property (arr_ready |-> arr_rd)
		else $error("ready without request");
	a_denied_zero: assert property (arr_denied |-> arr_rvalid && arr_rdata == 16'h0000)
		else $error("refused read leaks data");
	a_lvl2_cause: assert property ($fell(debug_enable) |-> $past(reg_wr) && $past(reg_addr) == FMCU_OFS_PROT
		&& ($past(reg_wdata) & 32'h0000_00FF) == 32'h0000_00CC)
		else $error("debug dropped without level 2 write");
	a_lvl2_frozen: assert property (!debug_enable |=> !debug_enable)
		else $error("level 2 left");
	a_irq_sticky: assert property ($fell(op_done_irq) |-> $past(reg_wr))
		else $error("irq dropped without software write");
	c_denied: cover property (arr_denied);
	c_irq: cover property ($rose(op_done_irq));
	c_lvl2: cover property ($fell(debug_enable));
endmodule // fmcu_flash_ctrl_unit_chk

// ### verif/fmcu_bus_master.sv
`timescale 1ns/1ps
// system-bus reader in place of the core
module fmcu_bus_master (
	input wire logic clk, // clock
	output logic arr_rd, // request
	output logic [15:0] arr_addr, // address
	input wire logic arr_ready, // taken
	input wire logic [15:0] arr_rdata, // data
	input wire logic arr_rvalid, // valid
	input wire logic arr_denied // refused
);
	initial begin
		arr_rd = 1'b0;
		arr_addr = 16'h0000;
	end
	// one halfword read, gap cycles idle first
	task automatic read(input logic [15:0] a, input int gap, output logic [15:0] d, output logic den,
		output logic ok);
		int n;
		logic got;
		ok = 1'b0;
		got = 1'b0;
		repeat (gap) @(posedge clk);
		arr_rd <= 1'b1;
		arr_addr <= a;
		for (n = 0; n < 200 && !ok; n++) begin
			@(negedge clk);
			ok = arr_ready;
		end
		@(posedge clk);
		arr_rd <= 1'b0;
		// released address shows inverse
		arr_addr <= ~a;
		for (n = 0; n < 8 && !got; n++) begin
			@(negedge clk);
			got = arr_rvalid;
		end
		d = arr_rdata;
		den = arr_denied;
		ok = ok & got;
		@(posedge clk);
	endtask
endmodule // fmcu_bus_master

// ### verif/fmcu_flash_ctrl_unit_tb.sv
`timescale 1ns/1ps
// register and array scenarios for the flash controller
module fmcu_flash_ctrl_unit_tb;
	import fmcu_pkg::*;
	logic clk = 1'b0; // clock
	logic sys_rst = 1'b1; // reset
	logic dbg_or_ram_boot = 1'b0; // debug boot
	logic bus_clk_equal = 1'b1; // clocks equal
	logic [7:0] reg_addr = 8'h00; // address
	logic [31:0] reg_wdata = 32'h0000_0000; // wdata
	logic reg_wr = 1'b0; // write
	logic reg_rd = 1'b0; // read
	logic sysmem_wr = 1'b0; // sysmem attempt
	logic [31:0] reg_rdata; // rdata
	logic arr_rd, arr_ready, arr_rvalid, arr_denied, op_done_irq, debug_enable; // array and status
	logic [15:0] arr_addr, arr_rdata; // array bus
	int n_mismatch = 0; // mismatches
	int compares = 0; // comparisons
	// 125 MHz clock
	always #4 clk = ~clk;
	fmcu_flash_ctrl_unit #(.PAGES(8), .ERASE_CYCLES(2)) fmcu_flash_ctrl_unit_inst (.clk(clk), .sys_rst(sys_rst),
		.bus_clk_equal(bus_clk_equal), .dbg_or_ram_boot(dbg_or_ram_boot), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_rd(arr_rd), .arr_addr(arr_addr),
		.arr_ready(arr_ready), .arr_rdata(arr_rdata), .arr_rvalid(arr_rvalid), .arr_denied(arr_denied),
		.sysmem_wr(sysmem_wr), .op_done_irq(op_done_irq), .debug_enable(debug_enable));
	fmcu_bus_master fmcu_bus_master_inst (.clk(clk), .arr_rd(arr_rd), .arr_addr(arr_addr),
		.arr_ready(arr_ready), .arr_rdata(arr_rdata), .arr_rvalid(arr_rvalid), .arr_denied(arr_denied));
	task automatic final_report;
		if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
		compares++;
		if ((got & mask) !== (exp & mask)) begin
			n_mismatch++;
			$display("BAD t=%0t got %h exp %h mask %h", $time, got, exp, mask);
		end
	endtask
	// one-cycle write strobe, then a gap cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp, mask);
	endtask
	task automatic achk(input logic [15:0] a, input logic [15:0] exp, input logic den_exp, input int gap);
		logic [15:0] d;
		logic den, ok;
		fmcu_bus_master_inst.read(a, gap, d, den, ok);
		chk({14'h0000, ok, den, d}, {14'h0000, 1'b1, den_exp, exp}, 32'h0003_FFFF);
	endtask
	// poll busy with a bound
	task automatic wait_idle;
		logic [31:0] s;
		int n;
		s = 32'h0000_0001;
		for (n = 0; n < 3000 && s[FMCU_ST_BUSY_BIT]; n++) rd(FMCU_OFS_STS, s);
		chk(s, 32'h0000_0000, 32'h0000_0001);
	endtask
	task automatic prog(input logic [15:0] a, input logic [15:0] d);
		wr(FMCU_OFS_STS, 32'h0000_0034);
		wr(FMCU_OFS_ADDR, {16'h0000, a});
		wr(FMCU_OFS_CTRL_B, {16'h0000, d});
		wait_idle;
	endtask
	// watchdog
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		final_report;
	end
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rchk(FMCU_OFS_ACR, 32'h0000_0010, 32'h0000_0010);
		rchk(FMCU_OFS_CTRL_A, 32'h0000_0080, 32'h0000_0080);
		wr(FMCU_OFS_ACR, 32'h0000_0008);
		rchk(FMCU_OFS_ACR, 32'h0000_0010, 32'h0000_0018);
		bus_clk_equal <= 1'b0;
		rchk(FMCU_OFS_ACR, 32'h0000_0010, 32'h0000_0030);
		bus_clk_equal <= 1'b1;
		wr(FMCU_OFS_KEY, FMCU_KEY_FIRST);
		wr(FMCU_OFS_KEY, FMCU_KEY_SECOND);
		rchk(FMCU_OFS_CTRL_A, 32'h0000_0000, 32'h0000_0080);
		wr(FMCU_OFS_CTRL_A, 32'h0000_0044);
		wait_idle;
		achk(16'h0010, FMCU_ERASED, 1'b0, 0);
		achk(16'h1FFE, FMCU_ERASED, 1'b0, 3);
		wr(FMCU_OFS_CTRL_A, 32'h0000_1001);
		prog(16'h0010, 16'h1234);
		rchk(FMCU_OFS_STS, 32'h0000_0020, 32'h0000_0034);
		chk({31'h0000_0000, op_done_irq}, 32'h0000_0001, 32'h0000_0001);
		achk(16'h0010, 16'h1234, 1'b0, 0);
		achk(16'h0012, FMCU_ERASED, 1'b0, 0);
		wr(FMCU_OFS_ADDR, 32'h0000_0010);
		wr(FMCU_OFS_CTRL_B, 32'h0000_5678);
		wait_idle;
		rchk(FMCU_OFS_STS, 32'h0000_0024, 32'h0000_0034);
		achk(16'h0010, 16'h1234, 1'b0, 0);
		wr(FMCU_OFS_STS, 32'h0000_0034);
		rchk(FMCU_OFS_STS, 32'h0000_0000, 32'h0000_0034);
		chk({31'h0000_0000, op_done_irq}, 32'h0000_0000, 32'h0000_0001);
		wr(FMCU_OFS_PROT, 32'h0000_01AA);
		prog(16'h0C00, 16'h0BEE);
		rchk(FMCU_OFS_STS, 32'h0000_0010, 32'h0000_0034);
		achk(16'h0C00, FMCU_ERASED, 1'b0, 0);
		prog(16'h1000, 16'hA5A4);
		rchk(FMCU_OFS_STS, 32'h0000_0020, 32'h0000_0034);
		wr(FMCU_OFS_ADDR, 32'h0000_1000);
		wr(FMCU_OFS_CTRL_A, 32'h0000_1042);
		wait_idle;
		achk(16'h1000, FMCU_ERASED, 1'b0, 0);
		achk(16'h0010, 16'h1234, 1'b0, 0);
		wr(FMCU_OFS_STS, 32'h0000_0034);
		sysmem_wr <= 1'b1;
		@(posedge clk);
		sysmem_wr <= 1'b0;
		rchk(FMCU_OFS_STS, 32'h0000_0010, 32'h0000_0010);
		wr(FMCU_OFS_PROT, 32'h0000_0000);
		dbg_or_ram_boot <= 1'b1;
		achk(16'h0010, 16'h0000, 1'b1, 0);
		dbg_or_ram_boot <= 1'b0;
		achk(16'h0010, 16'h1234, 1'b0, 2);
		wr(FMCU_OFS_CTRL_A, 32'h0000_1001);
		prog(16'h1002, 16'h00C2);
		achk(16'h1002, 16'h00C2, 1'b0, 0);
		wr(FMCU_OFS_PROT, 32'h0000_00AA);
		wait_idle;
		dbg_or_ram_boot <= 1'b1;
		achk(16'h0010, FMCU_ERASED, 1'b0, 0);
		achk(16'h1002, FMCU_ERASED, 1'b0, 0);
		dbg_or_ram_boot <= 1'b0;
		wr(FMCU_OFS_PROT, 32'h0000_00CC);
		chk({31'h0000_0000, debug_enable}, 32'h0000_0000, 32'h0000_0001);
		achk(16'h0010, 16'h0000, 1'b1, 0);
		wr(FMCU_OFS_PROT, 32'h0000_00AA);
		chk({31'h0000_0000, debug_enable}, 32'h0000_0000, 32'h0000_0001);
		wr(FMCU_OFS_CTRL_B, 32'h0000_0001);
		rchk(FMCU_OFS_CTRL_A, 32'h0000_0080, 32'h0000_0080);
		wr(FMCU_OFS_KEY, 32'h1111_1111);
		wr(FMCU_OFS_KEY, FMCU_KEY_FIRST);
		wr(FMCU_OFS_KEY, FMCU_KEY_SECOND);
		rchk(FMCU_OFS_CTRL_A, 32'h0000_0080, 32'h0000_0080);
		final_report;
	end
endmodule // fmcu_flash_ctrl_unit_tb

bind fmcu_flash_ctrl_unit fmcu_flash_ctrl_unit_chk fmcu_flash_ctrl_unit_chk_inst (.clk(clk), .sys_rst(sys_rst),
	.bus_clk_equal(bus_clk_equal), .dbg_or_ram_boot(dbg_or_ram_boot), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_rd(arr_rd),
	.arr_addr(arr_addr), .arr_ready(arr_ready), .arr_rdata(arr_rdata), .arr_rvalid(arr_rvalid),
	.arr_denied(arr_denied), .sysmem_wr(sysmem_wr), .op_done_irq(op_done_irq), .debug_enable(debug_enable));
